// ### hw/hub_string_and_port_power_regs.sv
// Functional notes
// - Product string length register at 0x14, resets zero.
// - Serial string length register at 0x15, resets zero.
// - Manufacturer string bytes 0x16 to 0x53, reset zero.
// - Product string bytes 0x54 to 0x91, reset zero.
// - Serial string bytes 0x92 to 0xCF.
// - Charge enable at 0xD0, bits 3:1 per port.
// - Enable bit one activates charging on port.
// - Power status at 0xE5 is read-only, bits 3:1.
// - Status one when host powered the port.
// - Status zero when unpowered or over-current.
// - Status mirrors host, over-current and charging state.
// - Over-current flag clears matching power status bit.
`timescale 1ns/1ps
`include "hub_regs_defs.svh"

module hub_string_and_port_power_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire hub_regs_pkg::reg_req_t req,
  output hub_regs_pkg::reg_rsp_t      rsp,
  input  wire hub_regs_pkg::port_in_t port_in,
  output logic [2:0]                  charge_port_active
);

  localparam int AREA = `STRING_AREA_BYTES;
  localparam int TOTAL = 3 * AREA;

  typedef struct packed {
    logic [7:0]            product_string_length;
    logic [7:0]            serial_string_length;
    logic [7:0]            charge_port_enable;
    hub_regs_pkg::reg_rsp_t rsp;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;

  // The three string areas sit back to back, so one array covers them all; the strings are only stored
  // here, and their character encoding is left to the configuring software.
  logic [7:0] text_bytes [TOTAL];
  logic [2:0] power_state;

  function automatic hub_regs_pkg::region_t decode(input logic [7:0] a);
    if (a == `ADDR_PRODUCT_STRING_LENGTH) begin
      return hub_regs_pkg::region_prod_len;
    end else if (a == `ADDR_SERIAL_STRING_LENGTH) begin
      return hub_regs_pkg::region_ser_len;
    end else if (a >= `ADDR_MAKER_FIRST && a <= `ADDR_SERIAL_LAST) begin
      return hub_regs_pkg::region_strings;
    end else if (a == `ADDR_CHARGE_PORT_ENABLE) begin
      return hub_regs_pkg::region_charge;
    end else if (a == `ADDR_PORT_POWER_STATE) begin
      return hub_regs_pkg::region_power;
    end
    return hub_regs_pkg::region_none;
  endfunction

  function automatic logic [7:0] byte_index(input logic [7:0] a);
    return a - `ADDR_MAKER_FIRST;
  endfunction

  hub_regs_pkg::region_t region;
  logic [7:0]            index;

  assign region = decode(req.addr);
  assign index  = byte_index(req.addr);

  always_comb begin
    next_state = state;
    next_state.rsp.valid = req.rd;
    next_state.rsp.rdata = `RESET_BYTE;
    if (req.wr) begin
      case (region)
        hub_regs_pkg::region_prod_len: begin
          next_state.product_string_length = req.wdata;
        end
        hub_regs_pkg::region_ser_len: begin
          next_state.serial_string_length = req.wdata;
        end
        hub_regs_pkg::region_charge: begin
          next_state.charge_port_enable = req.wdata & `CHARGE_ENABLE_MASK;
        end
        default: begin
          // Writes to the status register and to unmapped addresses are dropped.
          next_state.product_string_length = state.product_string_length;
        end
      endcase
    end
    if (req.rd) begin
      case (region)
        hub_regs_pkg::region_prod_len: begin
          next_state.rsp.rdata = state.product_string_length;
        end
        hub_regs_pkg::region_ser_len: begin
          next_state.rsp.rdata = state.serial_string_length;
        end
        hub_regs_pkg::region_strings: begin
          next_state.rsp.rdata = text_bytes[index];
        end
        hub_regs_pkg::region_charge: begin
          next_state.rsp.rdata = state.charge_port_enable;
        end
        hub_regs_pkg::region_power: begin
          next_state.rsp.rdata = {4'h0, power_state, 1'b0};
        end
        default: begin
          next_state.rsp.rdata = `RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TOTAL; g++) begin : g_text
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          text_bytes[g] <= `RESET_BYTE;
        end else if (req.wr && region == hub_regs_pkg::region_strings && index == 8'(g)) begin
          text_bytes[g] <= req.wdata;
        end
      end
    end
  endgenerate

  assign charge_port_active = state.charge_port_enable[`PORT_FIELD_LSB +: 3];

  port_power_mirror u_mirror (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .port_in       (port_in),
    .charge_enable (charge_port_active),
    .power_state   (power_state)
  );

  assign rsp = state.rsp;

endmodule // hub_string_and_port_power_regs

// ### hw/hub_regs_defs.svh
`ifndef HUB_REGS_DEFS_SVH
`define HUB_REGS_DEFS_SVH

`define ADDR_PRODUCT_STRING_LENGTH 8'h14
`define ADDR_SERIAL_STRING_LENGTH  8'h15
`define ADDR_MAKER_FIRST           8'h16
`define ADDR_MAKER_LAST            8'h53
`define ADDR_PRODUCT_FIRST         8'h54
`define ADDR_PRODUCT_LAST          8'h91
`define ADDR_SERIAL_FIRST          8'h92
`define ADDR_SERIAL_LAST           8'hCF
`define ADDR_CHARGE_PORT_ENABLE    8'hD0
`define ADDR_PORT_POWER_STATE      8'hE5
`define RESET_BYTE                 8'h00
`define CHARGE_ENABLE_MASK         8'h0E
`define PORT_FIELD_LSB             1
`define STRING_AREA_BYTES          62

`endif

// ### hw/hub_regs_pkg.sv
package hub_regs_pkg;

  typedef enum logic [2:0] {
    region_none,
    region_prod_len,
    region_ser_len,
    region_strings,
    region_charge,
    region_power
  } region_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [2:0] host_power_on;
    logic [2:0] overcurrent_flags;
    logic [2:0] charge_hold_power;
  } port_in_t;

endpackage

// ### hw/port_power_mirror.sv
`timescale 1ns/1ps
`include "hub_regs_defs.svh"

module port_power_mirror (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire hub_regs_pkg::port_in_t   port_in,
  input  wire logic [2:0]               charge_enable,
  output logic      [2:0]               power_state
);

  typedef struct packed {
    logic [2:0] power;
  } mirror_state_t;

  mirror_state_t state;
  mirror_state_t next_state;

  always_comb begin
    next_state = state;
    for (int i = 0; i < 3; i++) begin
      // A port counts as powered from the host request, or from charging support when its enable is set.
      next_state.power[i] = (port_in.host_power_on[i] | (charge_enable[i] & port_in.charge_hold_power[i]))
                            & ~port_in.overcurrent_flags[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign power_state = state.power;

endmodule // port_power_mirror

// ### tb/regs_monitor.sv
`timescale 1ns/1ps
module regs_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire hub_regs_pkg::reg_req_t req,
  input wire hub_regs_pkg::reg_rsp_t rsp,
  input wire hub_regs_pkg::port_in_t port_in,
  input wire logic [2:0]             charge_port_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_read_answer: assert property (req.rd |=> rsp.valid) else $error("read unanswered");
  chk_no_spurious: assert property (!req.rd |=> !rsp.valid) else $error("stray answer");
  chk_idle_zero: assert property (!rsp.valid |-> rsp.rdata == 8'h00) else $error("idle data");
  chk_charge_write: assert property (req.wr && req.addr == 8'hD0 |=>
    charge_port_active == $past(req.wdata[3:1])) else $error("enable write");
  chk_charge_hold: assert property (!(req.wr && req.addr == 8'hD0) |=>
    $stable(charge_port_active)) else $error("enable moved");
  chk_status_ro: assert property (req.rd && req.addr == 8'hE5 |=>
    rsp.rdata[7:4] == 4'h0 && !rsp.rdata[0]) else $error("reserved status");
  chk_status_value: assert property (req.rd && req.addr == 8'hE5 |=> rsp.rdata[3:1] ==
    $past((port_in.host_power_on | (charge_port_active & port_in.charge_hold_power))
    & ~port_in.overcurrent_flags, 2)) else $error("status value");
  chk_len_readback: assert property (req.wr && req.addr == 8'h14 ##1 req.rd && req.addr == 8'h14
    |=> rsp.rdata == $past(req.wdata, 2)) else $error("length readback");
endmodule // regs_monitor

// ### tb/soc_cfg_model.sv
`timescale 1ns/1ps
module soc_cfg_model (
  input wire logic                   clk_sys,
  output hub_regs_pkg::reg_req_t     req,
  input wire hub_regs_pkg::reg_rsp_t rsp
);
  initial req = '0;
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
  endtask
  // Released lines flip so a stale address is never mistaken for a held one.
  task automatic idle();
    @(posedge clk_sys) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask
  task automatic put_char(input logic [7:0] a, input logic [15:0] c);
    put(1'b1, a, c[7:0]);
    put(1'b1, a + 8'h01, c[15:8]);
  endtask
endmodule // soc_cfg_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic                   clk_sys;
  logic                   rst_b;
  hub_regs_pkg::reg_req_t req;
  hub_regs_pkg::reg_rsp_t rsp;
  hub_regs_pkg::port_in_t port_in;
  logic [2:0]             charge_port_active;
  int                     failures;
  int                     num_checks;
  logic [23:0]            rows [12] = '{24'h145A5A, 24'h15A5A5, 24'h161111, 24'h532222, 24'h543333,
    24'h914444, 24'h925555, 24'hCF6666, 24'hD0FF0E, 24'hE5FF00, 24'hD17700, 24'h137700};
  hub_string_and_port_power_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rsp(rsp),
    .port_in(port_in), .charge_port_active(charge_port_active));
  soc_cfg_model soc (.clk_sys(clk_sys), .req(req), .rsp(rsp));
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    soc.put(1'b0, a, 8'h00);
    soc.idle();
    cmp(rsp, {1'b1, e});
  endtask
  task automatic st(input logic [8:0] p, input logic [7:0] e);
    port_in = p;
    chk(8'hE5, e);
  endtask
  task automatic test_done();
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial #200000 begin
    failures++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    port_in = '0;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    for (int a = 8'h14; a <= 8'hE5; a++) chk(a[7:0], 8'h00);
    foreach (rows[i]) begin
      soc.put(1'b1, rows[i][23:16], rows[i][15:8]);
      chk(rows[i][23:16], rows[i][7:0]);
    end
    soc.put_char(8'h52, 16'h20AC);
    chk(8'h52, 8'hAC);
    chk(8'h53, 8'h20);
    cmp({6'h00, charge_port_active}, 9'h007);
    st(9'h140, 8'h0A);
    st(9'h148, 8'h08);
    st(9'h002, 8'h04);
    soc.put(1'b1, 8'hD0, 8'h00);
    soc.idle();
    st(9'h002, 8'h00);
    cmp({6'h00, charge_port_active}, 9'h000);
    soc.put(1'b1, 8'h15, 8'h3C);
    soc.put(1'b1, 8'hD0, 8'h04);
    soc.idle();
    // A reset in mid-run must clear what software stored, strings included.
    rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    cmp({6'h00, charge_port_active}, 9'h000);
    chk(8'h15, 8'h00);
    chk(8'hD0, 8'h00);
    chk(8'h92, 8'h00);
    test_done();
  end
endmodule // tb
bind hub_string_and_port_power_regs regs_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
  .rsp(rsp), .port_in(port_in), .charge_port_active(charge_port_active));
